/* hw/pslt_pkg.sv */
// Package for the PCM highway slot assigner: register map, field layout,
// reset values and timing figures.
// Assumes a 125 MHz system clock and a 32-bit Avalon-MM register bus.
package pslt_pkg;
  // Channel count and widths
  localparam int NCH         = 4;          // Voice channels
  localparam int SLOT_W      = 7;          // Time slot number width
  localparam int OFS_W       = 3;          // Clock slot (bit offset) width
  localparam int CNT_W       = 11;         // Bit position within a frame
  localparam int ADDR_W      = 6;          // Byte address width

  // Register byte offsets
  localparam logic [5:0] REG_CTRL    = 6'h00;  // Mode control
  localparam logic [5:0] REG_BITOFS  = 6'h04;  // Tx and rx bit offsets
  localparam logic [5:0] REG_GCI     = 6'h08;  // GCI monitor and control bytes
  localparam logic [5:0] REG_STATUS  = 6'h0C;  // Measured frame length
  localparam logic [5:0] REG_CHCFG   = 6'h10;  // Per channel slots, one word each
  localparam logic [5:0] REG_TXDATA  = 6'h20;  // Per channel latched tx sample

  // Control register bit positions
  localparam int CTRL_MULAW  = 0;          // 1 = mu-law, 0 = A-law
  localparam int CTRL_LINEAR = 1;          // 16-bit linear coding
  localparam int CTRL_SIGNAL = 2;          // Signaling slot after sample
  localparam int CTRL_RISE   = 3;          // Tx changes on rising bit clock
  localparam int CTRL_ALT    = 4;          // Signaling bit 6 from alternate input
  localparam int CTRL_GCIDBL = 5;          // GCI bit clock at twice data rate
  localparam int CTRL_W      = 6;

  // Field positions
  localparam int TXOFS_LSB   = 0;
  localparam int RXOFS_LSB   = 8;
  localparam int GCIMON_LSB  = 0;
  localparam int GCICTL_LSB  = 8;
  localparam int TXSLOT_LSB  = 0;
  localparam int RXSLOT_LSB  = 8;
  localparam int TXPORT_LSB  = 16;
  localparam int RXPORT_BIT  = 20;
  localparam int SIG_SUP1    = 7;
  localparam int SIG_SUP2    = 6;
  localparam int SIG_CLOCK_FAIL_FLAG   = 2;

  // Reset values
  localparam logic [CTRL_W-1:0] RST_CTRL   = 6'h00;
  localparam logic [OFS_W-1:0]  RST_OFS    = 3'h0;
  localparam logic [1:0]        RST_TXPORT = 2'h1;  // Port A only
  localparam logic              RST_RXPORT = 1'b0;  // Port A

  // Timing: the fastest bit clock must leave room for the three-stage sampler
  localparam int SYS_KHZ     = 125000;
  localparam int PCLK_MAX_KHZ = 8192;
  localparam int PCLK_HALF_CYC = SYS_KHZ / (2 * PCLK_MAX_KHZ);

  // Byte order inside one GCI channel
  typedef enum logic [1:0] {
    PSLT_GCI_VOICE1 = 2'b00,
    PSLT_GCI_VOICE2 = 2'b01,
    PSLT_GCI_MON    = 2'b10,
    PSLT_GCI_CTL    = 2'b11
  } pslt_gci_byte_t;
endpackage : pslt_pkg

/* hw/pslt_slot_assigner.sv */
// PCM highway time slot assigner for four voice channels, with GCI upstream.
// Assumes bit clock, frame sync and highway data arrive as pins, sampled by
// the 125 MHz system clock; registers sit on Avalon-MM with waitrequest.
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module pslt_slot_assigner #(
  parameter int NUM_CH = 4                          // Voice channels served
) (
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_rst,
  // Avalon-MM slave
  input  wire logic [pslt_pkg::ADDR_W-1:0] i_avs_address,
  input  wire logic                      i_avs_read,
  input  wire logic                      i_avs_write,
  input  wire logic [31:0]               i_avs_writedata,
  input  wire logic [3:0]                i_avs_byteenable,
  output logic      [31:0]               o_avs_readdata,
  output logic                           o_avs_waitrequest,
  // Highway pins
  input  wire logic                      i_pcm_clk,
  input  wire logic                      i_frame_sync,
  input  wire logic                      i_rx_port_a,
  input  wire logic                      i_rx_port_b,
  input  wire logic                      i_gci_mode,
  input  wire logic                      i_gci_chan_sel0,
  input  wire logic                      i_gci_chan_sel1,
  input  wire logic                      i_supervision_in1,
  input  wire logic                      i_supervision_in2,
  input  wire logic                      i_supervision_in1_alt,
  input  wire logic                      i_clock_fail_flag,
  output logic                           o_tx_port_a,
  output logic                           o_tx_port_a_oe,
  output logic                           o_tx_port_b,
  output logic                           o_tx_port_b_oe,
  output logic                           o_tx_strobe_a_n,
  output logic                           o_tx_strobe_b_n,
  // Sample side
  input  wire logic [16*pslt_pkg::NCH-1:0] i_tx_sample,
  output logic      [16*pslt_pkg::NCH-1:0] o_rx_sample,
  output logic      [pslt_pkg::NCH-1:0]  o_rx_valid
);
  import pslt_pkg::*;

  // The map and the flat sample ports are laid out for four channels
  if (NUM_CH != NCH || PCLK_HALF_CYC < 3) begin : g_bad_param
    $error("pslt_slot_assigner: unsupported channel count or clock ratio");
  end

  // Pin sampler: stage one feeds only stage two; stage three gives edges.
  // Not reset, so it already holds the true pin levels when reset ends and
  // no false bit clock edge follows the release.
  localparam int NSYNC = 11;
  logic [NSYNC-1:0] pin_raw, s1_q, s2_q, s3_q;
  assign pin_raw = {i_clock_fail_flag, i_supervision_in1_alt, i_supervision_in2,
                    i_supervision_in1, i_gci_chan_sel1, i_gci_chan_sel0,
                    i_rx_port_b, i_rx_port_a, i_frame_sync, i_pcm_clk, i_gci_mode};
  always_ff @(posedge i_clk_sys) begin
    s1_q <= pin_raw;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end
  logic clk_s, fs_s, clk_rise, clk_fall;
  assign clk_s    = s2_q[1];
  assign fs_s     = s2_q[2];
  assign clk_rise = clk_s & ~s3_q[1];
  assign clk_fall = ~clk_s & s3_q[1];

  // Register file
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;                 // Mode control
  logic [OFS_W-1:0]  txofs_q, txofs_d, rxofs_q, rxofs_d;
  logic [7:0]        gmon_q, gmon_d, gctl_q, gctl_d; // GCI monitor and control
  logic [SLOT_W-1:0] txslot_q [NCH], txslot_d [NCH];
  logic [SLOT_W-1:0] rxslot_q [NCH], rxslot_d [NCH];
  logic [1:0]        txport_q [NCH], txport_d [NCH]; // Bit0 port A, bit1 port B
  logic              rxport_q [NCH], rxport_d [NCH]; // 1 = port B
  logic [31:0]       rdata_d;
  logic              wait_d;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
    return old;
  endfunction : merge

  logic [15:0]    txlat_q [NCH];                     // Sample on the highway now
  logic [CNT_W-1:0] flen_q;                          // Last measured frame length

  // Register next state: one wait cycle, then the access completes; a write
  // lands only at the edge where waitrequest is seen low
  always_comb begin
    logic [31:0] cur;
    logic        take;
    cur      = '0;
    take     = (i_avs_read | i_avs_write) & o_avs_waitrequest;
    wait_d   = ~take;
    ctrl_d   = ctrl_q;
    txofs_d  = txofs_q;
    rxofs_d  = rxofs_q;
    gmon_d   = gmon_q;
    gctl_d   = gctl_q;
    txslot_d = txslot_q;
    rxslot_d = rxslot_q;
    txport_d = txport_q;
    rxport_d = rxport_q;
    case (i_avs_address)
      REG_CTRL:   cur = 32'(ctrl_q);
      REG_BITOFS: cur = (32'(txofs_q) << TXOFS_LSB) | (32'(rxofs_q) << RXOFS_LSB);
      REG_GCI:    cur = (32'(gmon_q) << GCIMON_LSB) | (32'(gctl_q) << GCICTL_LSB);
      REG_STATUS: cur = 32'(flen_q);
      default: begin
        for (int c = 0; c < NCH; c++) begin
          if (i_avs_address == REG_CHCFG + 6'(4*c)) begin
            cur = (32'(txslot_q[c]) << TXSLOT_LSB) | (32'(rxslot_q[c]) << RXSLOT_LSB)
                | (32'(txport_q[c]) << TXPORT_LSB) | (32'(rxport_q[c]) << RXPORT_BIT);
          end
          if (i_avs_address == REG_TXDATA + 6'(4*c)) begin
            cur = 32'(txlat_q[c]);
          end
        end
      end
    endcase
    rdata_d = (take & i_avs_read) ? cur : o_avs_readdata;
    if (i_avs_write & ~o_avs_waitrequest) begin
      cur = merge(cur, i_avs_writedata, i_avs_byteenable);
      case (i_avs_address)
        REG_CTRL:   ctrl_d = cur[CTRL_W-1:0];
        REG_BITOFS: begin
          txofs_d = cur[TXOFS_LSB +: OFS_W];
          rxofs_d = cur[RXOFS_LSB +: OFS_W];
        end
        REG_GCI: begin
          gmon_d = cur[GCIMON_LSB +: 8];
          gctl_d = cur[GCICTL_LSB +: 8];
        end
        default: begin
          // Unmapped and read-only words ignore writes
          for (int c = 0; c < NCH; c++) begin
            if (i_avs_address == REG_CHCFG + 6'(4*c)) begin
              txslot_d[c] = cur[TXSLOT_LSB +: SLOT_W];
              rxslot_d[c] = cur[RXSLOT_LSB +: SLOT_W];
              txport_d[c] = cur[TXPORT_LSB +: 2];
              rxport_d[c] = cur[RXPORT_BIT];
            end
          end
        end
      endcase
    end
  end

  // Register storage
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctrl_q            <= RST_CTRL;
      txofs_q           <= RST_OFS;
      rxofs_q           <= RST_OFS;
      gmon_q            <= 8'hFF;
      gctl_q            <= 8'hFF;
      o_avs_readdata    <= 32'h0000_0000;
      o_avs_waitrequest <= 1'b1;
      for (int c = 0; c < NCH; c++) begin
        txslot_q[c] <= SLOT_W'(c);
        rxslot_q[c] <= SLOT_W'(c);
        txport_q[c] <= RST_TXPORT;
        rxport_q[c] <= RST_RXPORT;
      end
    end else begin
      ctrl_q            <= ctrl_d;
      txofs_q           <= txofs_d;
      rxofs_q           <= rxofs_d;
      gmon_q            <= gmon_d;
      gctl_q            <= gctl_d;
      o_avs_readdata    <= rdata_d;
      o_avs_waitrequest <= wait_d;
      txslot_q          <= txslot_d;
      rxslot_q          <= rxslot_d;
      txport_q          <= txport_d;
      rxport_q          <= rxport_d;
    end
  end

  // Mode decode; GCI forces companded, no signaling and one port
  logic gci, lin, sig, mulaw;
  assign gci   = s2_q[0];                            // Strap pin, sampled
  assign lin   = ctrl_q[CTRL_LINEAR] & ~gci;
  assign sig   = ctrl_q[CTRL_SIGNAL] & ~gci & ~lin;
  assign mulaw = ctrl_q[CTRL_MULAW];

  // Bit steps: tx on the chosen edge, rx on the other; GCI halves when asked
  logic gdiv_q, gdiv_d, tx_step, rx_step, edge_tx, edge_rx;
  assign edge_tx = ctrl_q[CTRL_RISE] ? clk_rise : clk_fall;
  assign edge_rx = ctrl_q[CTRL_RISE] ? clk_fall : clk_rise;
  assign gdiv_d  = (gci & ctrl_q[CTRL_GCIDBL] & edge_tx) ? ~gdiv_q : gdiv_q;
  assign tx_step = edge_tx & ~(gci & ctrl_q[CTRL_GCIDBL] & gdiv_q);
  assign rx_step = edge_rx & ~(gci & ctrl_q[CTRL_GCIDBL] & gdiv_q);

  // Position of a bit after the offset; before the offset it is still the
  // tail of the last frame, so a late slot runs on past frame sync
  function automatic logic [CNT_W-1:0] pos(input logic [CNT_W-1:0] cnt,
                                           input logic [OFS_W-1:0] ofs,
                                           input logic [CNT_W-1:0] flen);
    if (cnt >= CNT_W'(ofs)) return cnt - CNT_W'(ofs);
    return flen + cnt - CNT_W'(ofs);
  endfunction : pos

  // Expand a companded byte to a 16-bit two's complement sample
  function automatic logic [15:0] expand(input logic [7:0] b, input logic mu);
    logic [7:0]  x;
    logic [15:0] mag;
    x = mu ? ~b : (b ^ 8'h55);
    if (mu) begin
      mag = ((16'({x[3:0], 3'h0}) + 16'h0084) << x[6:4]) - 16'h0084;
    end else if (x[6:4] == 3'h0) begin
      mag = 16'({x[3:0], 4'h8});
    end else begin
      mag = (16'({x[3:0], 4'h0}) + 16'h0108) << (x[6:4] - 3'h1);
    end
    // A-law sign bit set means positive, mu-law sign bit set also means positive
    return (x[7] ^ mu) ? mag : 16'(-mag);
  endfunction : expand

  // Frame counters and transmit shifter state
  logic [CNT_W-1:0] tcnt_q, tcnt_d, rcnt_q, rcnt_d, flen_d, tnow, rnow, tp, rp;
  logic [15:0]      txlat_d [NCH];
  logic             da_d, db_d, oea_d, oeb_d;
  logic [7:0]       sigbyte;
  assign sigbyte = (8'(s2_q[7]) << SIG_SUP1)
                 | (8'(ctrl_q[CTRL_ALT] ? s2_q[9] : s2_q[8]) << SIG_SUP2)
                 | (8'(s2_q[10]) << SIG_CLOCK_FAIL_FLAG);
  assign tnow = fs_s ? '0 : ((&tcnt_q) ? tcnt_q : tcnt_q + 1'b1);
  assign rnow = fs_s ? '0 : ((&rcnt_q) ? rcnt_q : rcnt_q + 1'b1);
  assign tp   = pos(tnow, gci ? '0 : txofs_q, flen_q);
  assign rp   = pos(rnow, rxofs_q, flen_q);

  // Transmit next state: pick the first channel owning this bit
  always_comb begin
    logic [CNT_W-1:0] rel;
    logic [15:0]      word;
    logic [1:0]       gsel;
    logic             hit;
    rel     = '0;
    word    = '0;
    hit     = 1'b0;
    gsel    = {s2_q[6], s2_q[5]};
    tcnt_d  = tx_step ? tnow : tcnt_q;
    flen_d  = (tx_step & fs_s) ? tcnt_q + 1'b1 : flen_q;
    txlat_d = txlat_q;
    da_d    = o_tx_port_a;
    db_d    = o_tx_port_b;
    oea_d   = o_tx_port_a_oe;
    oeb_d   = o_tx_port_b_oe;
    if (tx_step) begin
      if (fs_s) begin
        for (int c = 0; c < NCH; c++) txlat_d[c] = i_tx_sample[16*c +: 16];
      end
      oea_d = 1'b0;
      oeb_d = 1'b0;
      da_d  = 1'b0;                                  // Park data while released
      db_d  = 1'b0;
      if (gci) begin
        rel = tp - {4'h0, gsel, 5'h00};
        if (tp >= {4'h0, gsel, 5'h00} && rel < CNT_W'(32)) begin
          case (pslt_gci_byte_t'(rel[4:3]))
            PSLT_GCI_VOICE1: word[15:8] = txlat_d[0][7:0];
            PSLT_GCI_VOICE2: word[15:8] = txlat_d[1][7:0];
            PSLT_GCI_MON:    word[15:8] = gmon_q;
            PSLT_GCI_CTL:    word[15:8] = gctl_q;
            default:         word[15:8] = 8'hFF;
          endcase
          da_d  = word[4'd15 - {1'b0, rel[2:0]}];
          oea_d = 1'b1;
        end
      end else begin
        for (int c = NCH - 1; c >= 0; c--) begin
          rel = tp - {1'b0, txslot_q[c], 3'h0};
          if (tp >= {1'b0, txslot_q[c], 3'h0} && rel < ((lin | sig) ? 11'd16 : 11'd8)) begin
            word = lin ? txlat_d[c] : {txlat_d[c][7:0], sig ? sigbyte : 8'h00};
            hit  = 1'b1;
            da_d = word[4'd15 - rel[3:0]];
            oea_d = txport_q[c][0];
            oeb_d = txport_q[c][1];
          end
        end
        db_d = da_d & oeb_d;
        da_d = da_d & oea_d;
        if (!hit) begin
          da_d = 1'b0;
          db_d = 1'b0;
        end
      end
    end
  end

  // Transmit registers; strobes are the inverse of the enables
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      gdiv_q          <= 1'b0;
      tcnt_q          <= '0;
      flen_q          <= '0;
      o_tx_port_a     <= 1'b0;
      o_tx_port_b     <= 1'b0;
      o_tx_port_a_oe  <= 1'b0;
      o_tx_port_b_oe  <= 1'b0;
      o_tx_strobe_a_n <= 1'b1;
      o_tx_strobe_b_n <= 1'b1;
      for (int c = 0; c < NCH; c++) txlat_q[c] <= 16'h0000;
    end else begin
      gdiv_q          <= gdiv_d;
      tcnt_q          <= tcnt_d;
      flen_q          <= flen_d;
      txlat_q         <= txlat_d;
      o_tx_port_a     <= da_d;
      o_tx_port_b     <= db_d;
      o_tx_port_a_oe  <= oea_d;
      o_tx_port_b_oe  <= oeb_d;
      o_tx_strobe_a_n <= ~oea_d;
      o_tx_strobe_b_n <= ~oeb_d;
    end
  end

  // Receive: each channel gathers bits from its own port and slot
  logic [15:0] rsh_q [NCH], rsh_d [NCH];
  logic [15:0] rout_d [NCH];
  logic [NCH-1:0] rval_d;
  always_comb begin
    logic [CNT_W-1:0] rel;
    logic [15:0]      nx;
    rel    = '0;
    nx     = '0;
    rcnt_d = rx_step ? rnow : rcnt_q;
    rsh_d  = rsh_q;
    rval_d = '0;
    for (int c = 0; c < NCH; c++) rout_d[c] = o_rx_sample[16*c +: 16];
    if (rx_step && !gci) begin
      for (int c = 0; c < NCH; c++) begin
        rel = rp - {1'b0, rxslot_q[c], 3'h0};
        nx  = {rsh_q[c][14:0], rxport_q[c] ? s2_q[4] : s2_q[3]};
        if (rp >= {1'b0, rxslot_q[c], 3'h0} && rel < (lin ? 11'd16 : 11'd8)) begin
          rsh_d[c] = nx;
          if (rel == (lin ? 11'd15 : 11'd7)) begin
            rout_d[c] = lin ? nx : expand(nx[7:0], mulaw);
            rval_d[c] = 1'b1;
          end
        end
      end
    end
  end

  // Receive registers
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rcnt_q      <= '0;
      o_rx_sample <= '0;
      o_rx_valid  <= '0;
      for (int c = 0; c < NCH; c++) rsh_q[c] <= 16'h0000;
    end else begin
      rcnt_q     <= rcnt_d;
      rsh_q      <= rsh_d;
      o_rx_valid <= rval_d;
      for (int c = 0; c < NCH; c++) o_rx_sample[16*c +: 16] <= rout_d[c];
    end
  end

  // Checks
  sequence bus_req;
    (i_avs_read | i_avs_write) & o_avs_waitrequest;
  endsequence
  sequence bus_done;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence
  chk_strobe_tracks_oe: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_tx_strobe_a_n == !o_tx_port_a_oe && o_tx_strobe_b_n == !o_tx_port_b_oe)
    else $error("strobe disagrees with drive enable");
  chk_frame_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    tx_step && fs_s |=> tcnt_q == '0) else $error("tx count not zero at frame sync");
  chk_rx_frame_zero: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    rx_step && fs_s |=> rcnt_q == '0) else $error("rx count not zero at frame sync");
  chk_edge_only: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $changed(o_tx_port_a_oe) |-> $past(tx_step)) else $error("tx changed off the edge");
  chk_gci_one_port: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    gci && $past(gci) && $past(tx_step) |-> !o_tx_port_b_oe) else $error("port B in GCI");
  chk_rx_valid_pulse: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_rx_valid[0] |=> !o_rx_valid[0]) else $error("rx valid longer than a cycle");
  chk_bus_one_wait: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    bus_req |=> bus_done) else $error("bus answer not after one wait cycle");
  chk_reset_slots: assert property (@(posedge i_clk_sys)
    $fell(i_rst) |-> txslot_q[1] == 7'h01 && rxslot_q[3] == 7'h03 && txofs_q == 3'h0)
    else $error("slot reset values wrong");
  chk_idle_low: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !o_tx_port_a_oe |-> !o_tx_port_a) else $error("idle data not parked");
endmodule : pslt_slot_assigner

`default_nettype wire

/* sim/pslt_highway_model.sv */
// Highway model: free bit clock, frame sync and receive data pins.
// Assumes the bench's system clock; frames hold whole slots only.
`timescale 1ns/100ps
`default_nettype none
module pslt_highway_model #(
  parameter int HALF  = 8,  // Sys clocks a half bit: 7.8 MHz, in range
  parameter int FRAME = 64  // Whole slots, so no fractional tail
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  output logic      o_pcm_clk,
  output logic      o_frame_sync,
  output logic      o_rx_port_a,
  output logic      o_rx_port_b
);
  int ph_q;   // Phase inside one bit period
  int bit_q;  // Bit position inside the frame
  // Rising edge advances the bit; sync spans the falling edge of bit 0
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ph_q         <= 0;
      bit_q        <= FRAME - 1;
      o_pcm_clk    <= 1'b1;
      o_frame_sync <= 1'b0;
    end else begin
      ph_q <= (ph_q == 2 * HALF - 1) ? 0 : ph_q + 1;
      if (ph_q == HALF - 1) begin
        o_pcm_clk <= 1'b0;
      end
      if (ph_q == 2 * HALF - 1) begin
        o_pcm_clk    <= 1'b1;
        bit_q        <= (bit_q == FRAME - 1) ? 0 : bit_q + 1;
        o_frame_sync <= (bit_q == FRAME - 1);
      end
    end
  end
  // Constant but different levels, so a swapped port shows at once
  assign o_rx_port_a = 1'b0;
  assign o_rx_port_b = 1'b1;
endmodule : pslt_highway_model
`default_nettype wire

/* sim/pcm_highway_slot_assigner_test.sv */
// Bench for the slot assigner: register bus tasks and frame captures.
// Assumes the highway model drives bit clock, frame sync and rx pins.
`timescale 1ns/100ps
`default_nettype none
module pcm_highway_slot_assigner_test;
  import pslt_pkg::*;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, wreq;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wdata = '0, rdata;
  logic pcm, fs, rxa, rxb, txa, txa_oe, txb, txb_oe, sa_n, sb_n;
  logic sup1 = 1'b1, sup2 = 1'b1, clock_fail_flag = 1'b1, gci = 1'b0;
  logic [1:0] gsel = 2'h0;       // GCI channel select pins
  logic [16*NCH-1:0] txs = '0, rxs;
  logic [NCH-1:0] rxv;
  logic [5:0] cap [64];          // One frame of sampled tx pins
  int fail_count = 0, checks = 0;
  int slot_c [NCH] = '{0, 1, 2, 3};
  logic [1:0] port_c [NCH] = '{2'h1, 2'h1, 2'h1, 2'h1};
  int ofs = 0, mode = 0;         // Mode 0 companded, 1 linear, 2 signaling, 3 GCI
  initial begin
    forever #4 clk = ~clk;
  end
  pslt_highway_model i_pslt_highway_model (.i_clk_sys(clk), .i_rst(rst), .o_pcm_clk(pcm),
    .o_frame_sync(fs), .o_rx_port_a(rxa), .o_rx_port_b(rxb));
  pslt_slot_assigner i_pslt_slot_assigner (.i_clk_sys(clk), .i_rst(rst), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_pcm_clk(pcm), .i_frame_sync(fs),
    .i_rx_port_a(rxa), .i_rx_port_b(rxb), .i_gci_mode(gci), .i_gci_chan_sel0(gsel[0]),
    .i_gci_chan_sel1(gsel[1]), .i_supervision_in1(sup1), .i_supervision_in2(sup2),
    .i_supervision_in1_alt(1'b0), .i_clock_fail_flag(clock_fail_flag), .o_tx_port_a(txa),
    .o_tx_port_a_oe(txa_oe), .o_tx_port_b(txb), .o_tx_port_b_oe(txb_oe),
    .o_tx_strobe_a_n(sa_n), .o_tx_strobe_b_n(sb_n), .i_tx_sample(txs), .o_rx_sample(rxs),
    .o_rx_valid(rxv));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low; bounded wait
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    rd    <= !w;
    wr    <= w;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (wreq === 1'b0) break;
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n == 50) begin
      fail_count++;
      end_of_test();
    end
  endtask : bus
  task automatic rd_chk(input string what, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, e, q);
  endtask : rd_chk
  task automatic wr32(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr32
  // Same slot both directions; rb picks receive port B
  task automatic setcfg(input int c, input int s, input logic [1:0] p, input logic rb);
    slot_c[c] = s;
    port_c[c] = p;
    wr32(REG_CHCFG + 6'(4 * c), 32'(rb) << 20 | 32'(p) << 16 | 32'(s) << 8 | 32'(s));
  endtask : setcfg
  // Captures a frame at each rising bit edge, when tx pins are settled
  task automatic frame_chk(input string what);
    int b, c, k;
    logic [15:0] w;
    logic [31:0] gw;
    logic ea, eb, ed;
    for (b = 0; b <= 200; b++) begin
      @(negedge pcm);
      if (fs === 1'b1) break;
    end
    if (b > 200) begin
      fail_count++;
      end_of_test();
    end
    for (b = 0; b < 64; b++) begin
      @(posedge pcm);
      #1;
      cap[b] = {txa_oe, txb_oe, txa, txb, sa_n, sb_n};
    end
    gw = {txs[7:0], txs[23:16], 8'h3C, 8'h96};  // Voice 1, voice 2, monitor, control
    for (b = 0; b < 64; b++) begin
      {ea, eb, ed} = 3'h0;
      k = b - 32 * int'(gsel);
      if (mode == 3 && k >= 0 && k < 32) begin  // GCI: port A only
        ea = 1'b1;
        ed = gw[31 - k];
      end
      for (c = NCH - 1; c >= 0 && mode != 3; c--) begin  // Lowest channel wins an overlap
        k = b - 8 * slot_c[c] - ofs;
        // Bit 6 comes from the alternate input, tied low, not from sup2
        w = (mode == 1) ? txs[16*c +: 16] : {txs[16*c +: 8], sup1, 1'b0, 3'h0, clock_fail_flag, 2'h0};
        if (k >= 0 && k < ((mode == 0) ? 8 : 16)) begin
          {eb, ea} = port_c[c];
          ed = w[15 - k];
        end
      end
      chk(what, {26'h0, ea, eb, ea & ed, eb & ed, !ea, !eb}, {26'h0, cap[b]});
    end
    $display("%s done", what);
  endtask : frame_chk
  task automatic t_reset();
    for (int c = 0; c < NCH; c++) begin
      rd_chk("chcfg", REG_CHCFG + 6'(4 * c), 32'h0001_0000 | c << 8 | c);
    end
    rd_chk("ctrl", REG_CTRL, 32'h0);
    rd_chk("bit offsets", REG_BITOFS, 32'h0);
    rd_chk("unmapped", 6'h3C, 32'h0);
    rd_chk("gci reset", REG_GCI, 32'h0000_FFFF);
    $display("reset values done");
  endtask : t_reset
  task automatic t_companded();
    txs <= 64'h12E7_345A_56C3_7881;
    frame_chk("companded frame");
    rd_chk("tx data", REG_TXDATA + 6'h04, 32'h0000_56C3);
  endtask : t_companded
  task automatic t_offset();
    ofs = 3;
    wr32(REG_BITOFS, 32'h0000_0003);
    setcfg(0, 5, 2'h3, 1'b0);
    frame_chk("offset frame");
    ofs = 0;
    wr32(REG_BITOFS, 32'h0);
  endtask : t_offset
  task automatic t_signal();
    for (int c = 0; c < NCH; c++) begin
      setcfg(c, 2 * c, 2'h1, c == 1);
    end
    mode = 2;
    wr32(REG_CTRL, 32'h0000_0014);
    frame_chk("signaling frame");
    chk("rx expand b", 32'h0000_0350, 32'(rxs[31:16]));
    chk("rx expand a", 32'h0000_EA80, 32'(rxs[15:0]));
  endtask : t_signal
  task automatic t_linear();
    int n;
    rd_chk("frame length", REG_STATUS, 32'd64);
    mode = 1;
    txs <= 64'h8001_7FFE_C3A5_0F5A;
    wr32(REG_CTRL, 32'h0000_0002);
    frame_chk("linear frame");
    for (n = 0; n < 1100; n++) begin
      @(posedge clk);
      if (rxv[1] === 1'b1) break;
    end
    if (n == 1100) begin
      fail_count++;
      end_of_test();
    end
    chk("rx port b", 32'h0000_FFFF, 32'(rxs[31:16]));
    @(posedge clk);
    chk("rx valid pulse", 32'h0, 32'(rxv[1]));
    chk("rx port a", 32'h0, 32'(rxs[15:0]));
  endtask : t_linear
  // Linear stays set in control, so GCI must ignore it
  task automatic t_gci();
    wr32(REG_GCI, 32'h0000_963C);
    rd_chk("gci bytes", REG_GCI, 32'h0000_963C);
    gsel <= 2'h1;
    gci  <= 1'b1;
    mode = 3;
    frame_chk("gci frame");
  endtask : t_gci
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_reset();
    t_companded();
    t_offset();
    t_signal();
    t_linear();
    t_gci();
    end_of_test();
  end
endmodule : pcm_highway_slot_assigner_test
`default_nettype wire
